// file: design/ile_cfg.svh
// Purpose: Offsets, field positions, reset values of the input unit
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Definitions only
`ifndef ILE_CFG_SVH
`define ILE_CFG_SVH

// Register byte offsets
`define ILE_OFS_FUNC0     8'h00
`define ILE_OFS_FUNC1     8'h04
`define ILE_OFS_FUNC2     8'h08
`define ILE_OFS_FILT      8'h0C
`define ILE_OFS_FEN       8'h10
`define ILE_OFS_EDGE      8'h14
`define ILE_OFS_STAT      8'h18
`define ILE_OFS_MASK      8'h1C
`define ILE_OFS_IMG       8'h20
`define ILE_OFS_RSTAT     8'h24

// Function field layout
`define ILE_FN_W          3
`define ILE_FN_PER_WORD   8

// Fast inputs and run/stop candidates
`define ILE_FAST_BASE     2
`define ILE_NUM_FAST      4
`define ILE_RUNSTOP_LIMIT 16

// Status and mask layout
`define ILE_ST_EVT_LSB    0
`define ILE_ST_LAT_LSB    4
`define ILE_ST_CFG_BIT    8
`define ILE_ST_W          9

// Reset values
`define ILE_FILT_RST      8'h04
`define ILE_FEN_RST       32'h0000_0000
`define ILE_EDGE_RST      8'h55
`define ILE_MASK_RST      9'h000

`endif

// file: design/ile_pkg.sv
// Purpose: Types of the input latch and event unit
// Assumes: ile_cfg.svh holds the numbers
// Notes:   APB carried as packed structs
package ile_pkg;

    typedef enum logic [2:0] {
        ILE_FN_PLAIN   = 3'b000,
        ILE_FN_RUNSTOP = 3'b001,
        ILE_FN_LATCH   = 3'b010,
        ILE_FN_EVENT   = 3'b011,
        ILE_FN_FCNT    = 3'b100,
        ILE_FN_HSC     = 3'b101,
        ILE_FN_PTO     = 3'b110
    } ile_func_e;

    typedef enum logic [1:0] {
        ILE_EDGE_NONE = 2'b00,
        ILE_EDGE_RISE = 2'b01,
        ILE_EDGE_FALL = 2'b10,
        ILE_EDGE_BOTH = 2'b11
    } ile_edge_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ile_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ile_apb_rsp_s;

endpackage : ile_pkg

// file: design/ile_filter.sv
// Purpose: Integrating bounce filter for one input
// Assumes: Input synchronous to ref_clk
// Notes:   Output registered; bypassed when not enabled
`timescale 1ns/1ns
module ile_filter
#(
    parameter int CW = 8
)
(
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic          raw,
    input  wire logic          en,
    input  wire logic [CW-1:0] thr,
    output logic               filt
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          filt_next;
    wire           at_top  = (cnt_reg >= thr);
    wire           at_zero = (cnt_reg == '0);

    // Count toward level, switch only at the ends
    assign cnt_next  = !en ? '0 :
                       (raw && !at_top) ? cnt_reg + 1'b1 :
                       (!raw && !at_zero) ? cnt_reg - 1'b1 : cnt_reg;
    assign filt_next = !en ? raw :
                       (raw && at_top) ? 1'b1 :
                       (!raw && at_zero) ? 1'b0 : filt;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            filt    <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            filt    <= filt_next;
        end
    end

endmodule : ile_filter

// file: design/ile_unit.sv
// Purpose: Input conditioning: filter, latch, events, function routing
// Assumes: scan_tick pulses once at the start of each program scan
// Notes:   APB slave with one wait state; level interrupt
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "ile_cfg.svh"

module ile_unit
    import ile_pkg::*;
#(
    parameter int N_IN   = 24,
    parameter int FILT_W = 8
)
(
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire ile_pkg::ile_apb_req_s apb_req,
    output ile_pkg::ile_apb_rsp_s    apb_rsp,
    input  wire logic [N_IN-1:0]     field_in,
    input  wire logic                scan_tick,
    output logic [N_IN-1:0]          in_image,
    output logic [3:0]               task_trig,
    output logic                     runstop_cmd,
    output logic [N_IN-1:0]          fcnt_in,
    output logic [N_IN-1:0]          hsc_in,
    output logic [N_IN-1:0]          pto_in,
    output logic                     irq
);
    import ile_pkg::*;

    localparam int NF = `ILE_NUM_FAST;
    localparam int FB = `ILE_FAST_BASE;
    localparam int SW = `ILE_ST_W;

    ile_func_e         fn_reg [N_IN];
    logic [FILT_W-1:0] filt_reg;
    logic [N_IN-1:0]   fen_reg;
    logic [2*NF-1:0]   edge_reg;
    logic [SW-1:0]     stat_reg;
    logic [SW-1:0]     stat_next;
    logic [SW-1:0]     mask_reg;
    logic [NF-1:0]     latch_reg;
    logic [NF-1:0]     latch_next;
    logic [N_IN-1:0]   filt_d_reg;
    logic [N_IN-1:0]   filt;
    logic [N_IN-1:0]   filt_en;
    logic [N_IN-1:0]   sel_rs;
    logic [N_IN-1:0]   sel_fc;
    logic [N_IN-1:0]   sel_hsc;
    logic [N_IN-1:0]   sel_pto;
    logic [N_IN-1:0]   img_next;
    logic [NF-1:0]     is_latch;
    logic [NF-1:0]     is_event;
    logic [NF-1:0]     rise;
    logic [NF-1:0]     fall;
    logic [NF-1:0]     ev_hit;
    logic [NF-1:0]     lat_hit;
    logic [3*N_IN-1:0] fn_flat;
    logic [95:0]       fn_pad;
    logic [5:0]        rs_count;
    logic [31:0]       rd_mux;
    logic              hit;

    // Function code test, used for every input
    function automatic logic fn_is(ile_func_e f, ile_func_e t);
        return f == t;
    endfunction : fn_is

    // APB phases
    wire acc        = apb_req.psel & apb_req.penable;
    wire pready_nxt = acc & ~apb_rsp.pready;
    wire wr_en      = acc & apb_rsp.pready & apb_req.pwrite & hit;
    wire [7:0] adr  = apb_req.paddr;
    wire [31:0] wd  = apb_req.pwdata;

    assign hit = (adr == `ILE_OFS_FUNC0) || (adr == `ILE_OFS_FUNC1) ||
                 (adr == `ILE_OFS_FUNC2) || (adr == `ILE_OFS_FILT)  ||
                 (adr == `ILE_OFS_FEN)   || (adr == `ILE_OFS_EDGE)  ||
                 (adr == `ILE_OFS_STAT)  || (adr == `ILE_OFS_MASK)  ||
                 (adr == `ILE_OFS_IMG)   || (adr == `ILE_OFS_RSTAT);

    assign fn_pad = 96'(fn_flat);

    always_comb
    begin
        case (adr)
            `ILE_OFS_FUNC0: rd_mux = {8'h00, fn_pad[23:0]};
            `ILE_OFS_FUNC1: rd_mux = {8'h00, fn_pad[47:24]};
            `ILE_OFS_FUNC2: rd_mux = {8'h00, fn_pad[71:48]};
            `ILE_OFS_FILT:  rd_mux = 32'(filt_reg);
            `ILE_OFS_FEN:   rd_mux = 32'(fen_reg);
            `ILE_OFS_EDGE:  rd_mux = 32'(edge_reg);
            `ILE_OFS_STAT:  rd_mux = 32'(stat_reg);
            `ILE_OFS_MASK:  rd_mux = 32'(mask_reg);
            `ILE_OFS_IMG:   rd_mux = 32'(in_image);
            `ILE_OFS_RSTAT: rd_mux = {25'h0000000, runstop_cmd, rs_count};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            apb_rsp <= '0;
        else
        begin
            apb_rsp.pready  <= pready_nxt;
            apb_rsp.pslverr <= pready_nxt & ~hit;
            apb_rsp.prdata  <= pready_nxt ? rd_mux : 32'h0000_0000;
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            filt_reg <= FILT_W'(`ILE_FILT_RST);
            fen_reg  <= N_IN'(`ILE_FEN_RST);
            edge_reg <= (2*NF)'(`ILE_EDGE_RST);
            mask_reg <= `ILE_MASK_RST;
        end
        else if (wr_en)
        begin
            if (adr == `ILE_OFS_FILT)
                filt_reg <= wd[FILT_W-1:0];
            if (adr == `ILE_OFS_FEN)
                fen_reg <= wd[N_IN-1:0];
            if (adr == `ILE_OFS_EDGE)
                edge_reg <= wd[2*NF-1:0];
            if (adr == `ILE_OFS_MASK)
                mask_reg <= wd[SW-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++)
        begin : g_in
            localparam int  WI  = gi / `ILE_FN_PER_WORD;
            localparam int  LI  = gi % `ILE_FN_PER_WORD;
            localparam bit  FST = (gi >= FB) && (gi < FB + NF);
            wire [7:0] fofs = `ILE_OFS_FUNC0 + 8'(4 * WI);

            // One function per input, plain after reset
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    fn_reg[gi] <= ILE_FN_PLAIN;
                else if (wr_en && adr == fofs)
                    fn_reg[gi] <= ile_func_e'(wd[3*LI +: 3]);
            end
            assign fn_flat[3*gi +: 3] = fn_reg[gi];

            assign sel_rs[gi]  = (gi < `ILE_RUNSTOP_LIMIT) &&
                                 fn_is(fn_reg[gi], ILE_FN_RUNSTOP);
            assign sel_fc[gi]  = fn_is(fn_reg[gi], ILE_FN_FCNT);
            assign sel_hsc[gi] = fn_is(fn_reg[gi], ILE_FN_HSC);
            assign sel_pto[gi] = fn_is(fn_reg[gi], ILE_FN_PTO);

            assign filt_en[gi] = fen_reg[gi] & (!FST ||
                                 fn_is(fn_reg[gi], ILE_FN_LATCH) ||
                                 fn_is(fn_reg[gi], ILE_FN_EVENT) ||
                                 fn_is(fn_reg[gi], ILE_FN_HSC));

            ile_filter #(.CW(FILT_W)) u_filt
            (
                .ref_clk (ref_clk),
                .sys_rst (sys_rst),
                .raw     (field_in[gi]),
                .en      (filt_en[gi]),
                .thr     (filt_reg),
                .filt    (filt[gi])
            );
        end

        for (gi = 0; gi < NF; gi++)
        begin : g_fast
            assign is_latch[gi] = fn_is(fn_reg[FB+gi], ILE_FN_LATCH);
            assign is_event[gi] = fn_is(fn_reg[FB+gi], ILE_FN_EVENT);
            assign rise[gi] = filt[FB+gi] & ~filt_d_reg[FB+gi];
            assign fall[gi] = ~filt[FB+gi] & filt_d_reg[FB+gi];
            assign ev_hit[gi] = is_event[gi] &
                                ((edge_reg[2*gi] & rise[gi]) |
                                 (edge_reg[2*gi+1] & fall[gi]));
            assign lat_hit[gi] = is_latch[gi] & rise[gi];
            assign latch_next[gi] = lat_hit[gi] |
                                    (latch_reg[gi] & ~scan_tick);
            assign img_next[FB+gi] = filt[FB+gi] |
                                     (is_latch[gi] & latch_reg[gi]);
        end

        for (gi = 0; gi < N_IN; gi++)
        begin : g_img
            if (gi < FB || gi >= FB + NF)
            begin : g_plain
                assign img_next[gi] = filt[gi];
            end
        end
    endgenerate

    always_comb
    begin
        rs_count = 6'h00;
        for (int i = 0; i < N_IN; i++)
            rs_count = rs_count + 6'(sel_rs[i]);
    end

    // Sticky status, set wins over clear
    assign stat_next = (stat_reg &
                        ~((wr_en && adr == `ILE_OFS_STAT) ?
                          wd[SW-1:0] : {SW{1'b0}})) |
                       {(rs_count > 6'h01), lat_hit, ev_hit};

    wire runstop_next = (rs_count == 6'h01) && |(filt & sel_rs);
    // Interrupt level from unmasked status
    wire irq_next     = |(stat_reg & mask_reg);

    // Edge history, latches and status
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            filt_d_reg <= '0;
            latch_reg  <= '0;
            stat_reg   <= '0;
        end
        else
        begin
            filt_d_reg <= filt;
            latch_reg  <= latch_next;
            stat_reg   <= stat_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            in_image <= '0;
        else if (scan_tick)
            in_image <= img_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            task_trig <= '0;
        else
            task_trig <= ev_hit;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            runstop_cmd <= 1'b0;
        else
            runstop_cmd <= runstop_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            fcnt_in <= '0;
            hsc_in  <= '0;
            pto_in  <= '0;
        end
        else
        begin
            fcnt_in <= filt & sel_fc;
            hsc_in  <= filt & sel_hsc;
            pto_in  <= filt & sel_pto;
        end
    end

    // Level interrupt
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= irq_next;
    end

endmodule : ile_unit

// file: verif/ile_unit_properties.sv
// Purpose: Port checks of the input unit
// Assumes: One clock, sync reset
// Notes:   Bound to ile_unit
`timescale 1ns/1ns
`include "ile_cfg.svh"
module ile_unit_chk
    import ile_pkg::*;
#(
    parameter int N_IN   = 24,
    parameter int FILT_W = 8
)
(
    input wire logic                  ref_clk,
    input wire logic                  sys_rst,
    input wire ile_pkg::ile_apb_req_s apb_req,
    input wire ile_pkg::ile_apb_rsp_s apb_rsp,
    input wire logic [N_IN-1:0]       field_in,
    input wire logic                  scan_tick,
    input wire logic [N_IN-1:0]       in_image,
    input wire logic [3:0]            task_trig,
    input wire logic                  runstop_cmd,
    input wire logic [N_IN-1:0]       fcnt_in,
    input wire logic [N_IN-1:0]       hsc_in,
    input wire logic [N_IN-1:0]       pto_in,
    input wire logic                  irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_access;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence s_answer;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence
    a_ready_one_wait: assert property (s_access |=> s_answer)
        else $error("pready not one cycle after access");
    a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_idle_zero: assert property (!apb_rsp.pready |->
        apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
        else $error("response not zero while idle");
    a_err_decode: assert property (apb_req.psel && apb_rsp.pready &&
        apb_req.paddr[1:0] == 2'h0 |->
        apb_rsp.pslverr == (apb_req.paddr > 8'h24))
        else $error("error flag wrong for address");
    genvar j;
    for (j = 0; j < 4; j++)
    begin : g_trig
        a_trig_pulse: assert property (task_trig[j] &&
            $past(task_trig[j]) |->
            $past(field_in[`ILE_FAST_BASE + j], 2) !=
            $past(field_in[`ILE_FAST_BASE + j], 3))
            else $error("trigger repeated without input change");
    end
    a_image_hold: assert property (!scan_tick |=> $stable(in_image))
        else $error("image changed between scans");
    a_roles_excl: assert property ((fcnt_in & hsc_in |
        hsc_in & pto_in | fcnt_in & pto_in) == '0)
        else $error("input routed to two functions");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !irq &&
        task_trig == 4'h0 && in_image == '0 && !runstop_cmd)
        else $error("outputs not cleared by reset");
endmodule : ile_unit_chk

bind ile_unit ile_unit_chk #(.N_IN(N_IN), .FILT_W(FILT_W)) i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .field_in(field_in), .scan_tick(scan_tick),
    .in_image(in_image), .task_trig(task_trig), .runstop_cmd(runstop_cmd),
    .fcnt_in(fcnt_in), .hsc_in(hsc_in), .pto_in(pto_in), .irq(irq));

// file: verif/ile_field_model.sv
// Purpose: Field inputs and scan engine beside the unit
// Assumes: Bench sets wanted levels at rising edges
// Notes:   Scan pulse every SCAN cycles
`timescale 1ns/1ns
module ile_field_model
#(
    parameter int N_IN = 24,
    parameter int SCAN = 40
)
(
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    input  wire logic [N_IN-1:0] lvl,
    output logic [N_IN-1:0]      field_in,
    output logic                 scan_tick
);
    int cnt = 0;
    always @(posedge ref_clk)
    begin
        field_in <= lvl;
        cnt <= (sys_rst || cnt == SCAN - 1) ? 0 : cnt + 1;
        scan_tick <= !sys_rst && cnt == SCAN - 1;
    end
endmodule : ile_field_model

// file: verif/input_latch_event_unit_bench.sv
// Purpose: Self-checking bench of the input unit
// Assumes: Filter off unless a test enables it
// Notes:   Scan period set by the field model
`timescale 1ns/1ns
`include "ile_cfg.svh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module input_latch_event_unit_bench;
    import ile_pkg::*;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    ile_apb_req_s req = '0;
    ile_apb_rsp_s rsp;
    logic [23:0]  lvl = '0, fld, img, fcnt, hsc, pto;
    logic         tick, rsc, irq, e;
    logic [3:0]   trig;
    logic [31:0]  q;
    int           bad_count = 0, checks = 0;
    always #20 ref_clk = ~ref_clk;
    ile_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(req),
        .apb_rsp(rsp), .field_in(fld), .scan_tick(tick), .in_image(img),
        .task_trig(trig), .runstop_cmd(rsc), .fcnt_in(fcnt), .hsc_in(hsc),
        .pto_in(pto), .irq(irq));
    ile_field_model i_fld (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .lvl(lvl), .field_in(fld), .scan_tick(tick));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (rsp.pready !== 1'b1)
            @(posedge ref_clk);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
        `CHK(e, 1'b0)
    endtask : rd
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : step
    task automatic scan();
        @(posedge ref_clk);
        while (tick !== 1'b1)
            @(posedge ref_clk);
        #1;
    endtask : scan
    task automatic count_trig(output int n);
        n = 0;
        repeat (10)
        begin
            @(posedge ref_clk);
            if (trig[1] === 1'b1)
                n++;
        end
    endtask : count_trig
    task automatic pulse_count(input logic use_hsc, output int n);
        lvl[2] <= 1'b1;
        step(3);
        lvl[2] <= 1'b0;
        n = 0;
        repeat (10)
        begin
            @(posedge ref_clk);
            if ((use_hsc ? hsc[2] : fcnt[2]) === 1'b1)
                n++;
        end
    endtask : pulse_count
    task automatic t_regs();
        rd(`ILE_OFS_FILT, 32'(`ILE_FILT_RST));
        rd(`ILE_OFS_EDGE, 32'(`ILE_EDGE_RST));
        rd(`ILE_OFS_FEN, `ILE_FEN_RST);
        apb(1'b0, 8'h28, 32'h0);
        `CHK(e, 1'b1)
        $display("test regs done");
    endtask : t_regs
    task automatic t_latch();
        apb(1'b1, `ILE_OFS_FUNC0, 32'h0000_0680);
        scan();
        @(posedge ref_clk);
        lvl[2] <= 1'b1;
        @(posedge ref_clk);
        lvl[2] <= 1'b0;
        scan();
        `CHK(img[2], 1'b1)
        scan();
        `CHK(img[2], 1'b0)
        rd(`ILE_OFS_STAT, 32'h0000_0010);
        lvl[2] <= 1'b1;
        scan();
        scan();
        apb(1'b1, `ILE_OFS_STAT, 32'h0000_01FF);
        lvl[2] <= 1'b0;
        scan();
        `CHK(img[2], 1'b0)
        rd(`ILE_OFS_STAT, 32'h0000_0000);
        $display("test latch done");
    endtask : t_latch
    task automatic t_event();
        int n;
        apb(1'b1, `ILE_OFS_MASK, 32'h0000_0002);
        for (int m = 1; m < 4; m++)
        begin
            apb(1'b1, `ILE_OFS_EDGE, 32'(m << 2));
            lvl[3] <= 1'b1;
            count_trig(n);
            `CHK(n, m % 2)
            lvl[3] <= 1'b0;
            count_trig(n);
            `CHK(n, m / 2)
        end
        lvl[3] <= 1'b1;
        @(posedge ref_clk);
        lvl[3] <= 1'b0;
        count_trig(n);
        `CHK(n, 2)
        `CHK(irq, 1'b1)
        apb(1'b1, `ILE_OFS_MASK, 32'h0000_0000);
        step(2);
        `CHK(irq, 1'b0)
        rd(`ILE_OFS_STAT, 32'h0000_0002);
        apb(1'b1, `ILE_OFS_STAT, 32'h0000_01FF);
        $display("test event done");
    endtask : t_event
    task automatic t_func();
        apb(1'b1, `ILE_OFS_FUNC1, 32'h0000_01AC);
        apb(1'b1, `ILE_OFS_FUNC0, 32'h0000_0001);
        lvl <= 24'h00_0701;
        step(4);
        `CHK(fcnt, 24'h00_0100)
        `CHK(hsc, 24'h00_0200)
        `CHK(pto, 24'h00_0400)
        `CHK(rsc, 1'b1)
        apb(1'b1, `ILE_OFS_FUNC0, 32'h0000_0009);
        step(2);
        `CHK(rsc, 1'b0)
        rd(`ILE_OFS_STAT, 32'h0000_0100);
        $display("test func done");
    endtask : t_func
    task automatic t_filter();
        int n;
        apb(1'b1, `ILE_OFS_FEN, 32'h0000_0100);
        lvl[8] <= 1'b0;
        step(12);
        lvl[8] <= 1'b1;
        step(3);
        lvl[8] <= 1'b0;
        n = 0;
        repeat (12)
        begin
            @(posedge ref_clk);
            if (fcnt[8] !== 1'b0)
                n++;
        end
        `CHK(n, 0)
        lvl[8] <= 1'b1;
        step(9);
        `CHK(fcnt[8], 1'b1)
        apb(1'b1, `ILE_OFS_FUNC0, 32'h0000_0100);
        apb(1'b1, `ILE_OFS_FEN, 32'h0000_0004);
        pulse_count(1'b0, n);
        `CHK(n, 3)
        apb(1'b1, `ILE_OFS_FUNC0, 32'h0000_0140);
        pulse_count(1'b1, n);
        `CHK(n, 0)
        $display("test filter done");
    endtask : t_filter
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_latch();
        t_event();
        t_func();
        t_filter();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        report_and_stop();
    end
endmodule : input_latch_event_unit_bench
